// *** dv/tb_top.sv ***
// Purpose: Self-checking bench for the conversion sequencer registers, start logic, sequencing and status.
// Assumes: Register strobes are driven directly; front-end inputs hold steady values.
// Notes: The conversion clock divider is shortened so whole sequences fit the run.
module tb_top
  import mcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Signals and design instance
  // ----------------------------------------
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  mcs_req_t req = '0;
  logic [7:0] reg_rdata;
  logic [7:0] adc_sample = 8'h5A;
  logic [1:0] diode_fault = 2'h0;
  logic [2:0] adc_chan;
  logic conv_active;
  int err_count = 0;
  int compares = 0;
  // Conversion clock period and cycle-mode rest used in this run.
  localparam int TB_TICK = 2;
  localparam int TB_WAIT = 4;

  // Clock at 40 MHz.
  always #12.5 clock = ~clock;

  mcs_sequencer #(.WAIT_TICKS(TB_WAIT), .TICK_DIV(TB_TICK)) mcs_sequencer_inst (
    .clock(clock),
    .rst_n(rst_n),
    .req(req),
    .reg_rdata(reg_rdata),
    .adc_sample(adc_sample),
    .diode_fault(diode_fault),
    .adc_chan(adc_chan),
    .conv_active(conv_active)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d.", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // Compares one value with its expectation.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One write strobe; entered and left just after a rising edge.
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clock);
    req <= '0;
    @(posedge clock);
  endtask : reg_write

  // One read strobe, then the registered answer is compared.
  task automatic check_read(input string name, input logic [7:0] addr, input logic [7:0] exp);
    req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clock);
    req <= '0;
    @(posedge clock);
    check(name, reg_rdata, exp);
  endtask : check_read

  // Counts cycles with conversion activity over a fixed span.
  task automatic count_active(input int span, output int hits);
    hits = 0;
    repeat (span) begin
      @(posedge clock);
      if (conv_active !== 1'b0) hits++;
    end
  endtask : count_active

  // Waits for an input number, counting edges; a timeout ends the run.
  task automatic wait_chan(input logic [2:0] want, input int bound, output int n);
    n = 0;
    while (adc_chan !== want && n < bound) begin
      @(posedge clock);
      n++;
    end
    if (adc_chan !== want) begin
      err_count++;
      $display("ERROR adc_chan expected %h seen %h", want, adc_chan);
      test_done();
    end
  endtask : wait_chan

  // Waits for a level of conversion activity, counting edges; a timeout ends the run.
  task automatic wait_active(input logic want, input int bound, output int n);
    n = 0;
    while (conv_active !== want && n < bound) begin
      @(posedge clock);
      n++;
    end
    if (conv_active !== want) begin
      err_count++;
      $display("ERROR conv_active expected %b seen %b", want, conv_active);
      test_done();
    end
  endtask : wait_active

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Default values after power-up reset.
  task automatic t_reset_values();
    check_read("start_rst", 8'h40, 8'h00);
    check_read("spec_rst", 8'h7C, 8'h40);
    check_read("limit_rst", 8'h44, 8'hFF);
    check_read("status_rst", 8'h41, 8'h00);
    check_read("setup_rst", 8'h7F, 8'h00);
  endtask : t_reset_values

  // Nothing converts until the start bit is written.
  task automatic t_idle_before_start();
    int hits;
    count_active(300, hits);
    check("idle_active", hits, 0);
  endtask : t_idle_before_start

  // Every averaging code and the mode bit are stored; refused places stay quiet.
  task automatic t_registers();
    for (int a = 0; a < 8; a++) begin
      reg_write(8'h7C, {a[2:0], 5'h02});
      check_read("avg_code", 8'h7C, {a[2:0], 5'h02});
    end
    reg_write(8'h7C, 8'h00);
    check_read("mode_clear", 8'h7C, 8'h00);
    reg_write(8'h41, 8'hFF);
    check_read("status_ro", 8'h41, 8'h00);
    reg_write(8'h10, 8'h5A);
    check_read("undefined", 8'h10, 8'h00);
  endtask : t_registers

  // Soft reset mid-conversion restores defaults and clears itself.
  task automatic t_soft_reset();
    int hits;
    reg_write(8'h44, 8'h33);
    reg_write(8'h7C, 8'hA2);
    reg_write(8'h40, 8'h01);
    reg_write(8'h7F, 8'h80);
    check_read("srst_self", 8'h7F, 8'h00);
    check_read("srst_spec", 8'h7C, 8'h40);
    check_read("srst_limit", 8'h44, 8'hFF);
    check_read("srst_start", 8'h40, 8'h00);
    count_active(50, hits);
    check("srst_idle", hits, 0);
  endtask : t_soft_reset

  // Start begins with remote one and holds it through most of its 16 averaged conversions.
  task automatic t_start();
    int n;
    int moves;
    int hits;
    reg_write(8'h40, 8'h01);
    n = 0;
    while (conv_active !== 1'b1 && n < 10) begin
      @(posedge clock);
      n++;
    end
    if (n == 10) begin
      err_count++;
      $display("ERROR conv_active expected 1 seen %b", conv_active);
      test_done();
    end
    check("first_chan", {5'h00, adc_chan}, 8'h00);
    moves = 0;
    repeat (3000) begin
      @(posedge clock);
      if (adc_chan !== 3'h0 || conv_active !== 1'b1) moves++;
    end
    check("chan_hold", moves, 0);
    check_read("start_rb", 8'h40, 8'h01);
    reg_write(8'h40, 8'h00);
    count_active(20, hits);
    check("stop_idle", hits, 0);
  endtask : t_start

  // Continuous then cycle monitoring of a constant input with remote two faulted.
  task automatic t_sequence();
    int n;
    reg_write(8'h46, 8'h50);
    reg_write(8'h7C, 8'h20);
    diode_fault <= 2'h2;
    reg_write(8'h40, 8'h01);
    wait_chan(3'h1, 4000, n);
    wait_chan(3'h2, 400, n);
    check("temp_len", n, 96 * TB_TICK);
    wait_chan(3'h3, 400, n);
    check("volt_len", n, 68 * TB_TICK);
    wait_chan(3'h0, 5000, n);
    check("tail_len", n, (4 * 68 + 16 * 96) * TB_TICK);
    check("cont_loop", conv_active, 1);
    check_read("read_rd1", 8'h20, 8'h5A);
    check_read("read_vcc", 8'h22, 8'h5A);
    check_read("read_rd2", 8'h27, 8'h80);
    check_read("status_hit", 8'h41, 8'h04);
    check_read("status_keep", 8'h41, 8'h04);
    check_read("fault_hit", 8'h42, 8'h02);
    reg_write(8'h7C, 8'h22);
    wait_active(1'b0, 9000, n);
    wait_active(1'b1, 100, n);
    check("rest_len", n, TB_WAIT * TB_TICK);
    check("restart_chan", adc_chan, 0);
    reg_write(8'h40, 8'h00);
    reg_write(8'h7F, 8'h80);
    check_read("srst_keep", 8'h22, 8'h5A);
    diode_fault <= 2'h0;
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check_read("por_keep", 8'h21, 8'h5A);
    check_read("por_status", 8'h41, 8'h00);
  endtask : t_sequence

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset_values();
    t_idle_before_start();
    t_registers();
    t_soft_reset();
    t_start();
    t_sequence();
    test_done();
  end
endmodule : tb_top

// *** include/mcs_defs.svh ***
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 40 MHz system clock and a 45 kHz conversion clock.
// Notes: Byte wide registers at byte offsets.
`ifndef MCS_DEFS_SVH
`define MCS_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MCS_OFF_START 8'h40
`define MCS_OFF_STAT 8'h41
`define MCS_OFF_DFLT 8'h42
`define MCS_OFF_LIM0 8'h44
`define MCS_OFF_READ0 8'h20
`define MCS_OFF_SPEC 8'h7C
`define MCS_OFF_SETUP 8'h7F
// ----------------------------------------
// Field positions, reset values and fault reading
// ----------------------------------------
`define MCS_START_BIT 0
`define MCS_MODE_BIT 1
`define MCS_INTEN_BIT 2
`define MCS_SRST_BIT 7
`define MCS_AVG_RST 3'h2
`define MCS_LIM_RST 8'hFF
`define MCS_FAULT_VAL 8'h80
// ----------------------------------------
// Timing
// ----------------------------------------
`define MCS_CLK_HZ 40000000
`define MCS_CONV_HZ 45000
`define MCS_TICK_DIV (`MCS_CLK_HZ / `MCS_CONV_HZ)
`define MCS_TEMP_TICKS 96
`define MCS_VOLT_TICKS 68
`define MCS_WAIT_S 1
`define MCS_WAIT_TICKS (`MCS_WAIT_S * `MCS_CONV_HZ)
`endif

// *** include/mcs_pkg.sv ***
// Purpose: Types shared by the conversion sequencer.
// Assumes: Nothing beyond the defines header.
// Notes: Sequencer states follow a Gray path.
package mcs_pkg;
  typedef enum logic [1:0] {
    MCS_IDLE = 2'h0,
    MCS_CONV = 2'h1,
    MCS_WAIT = 2'h3
  } mcs_state_t;

  // Register access strobe group from the serial slave.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mcs_req_t;

  // Whole state of the sequencer except the reading registers.
  typedef struct packed {
    mcs_state_t state;
    logic start;
    logic mode;
    logic inten;
    logic [2:0] avg;
    logic [7:0][7:0] limit;
    logic [7:0] status;
    logic [1:0] dstatus;
    logic [7:0] viol;
    logic [1:0] dviol;
    logic [2:0] chan;
    logic [9:0] div;
    logic [6:0] ticks;
    logic [6:0] navg;
    logic [14:0] sum;
    logic [15:0] wait_cnt;
    logic [7:0] rdata;
    logic busy;
  } mcs_st_t;
endpackage : mcs_pkg

// *** src/mcs_sequencer.sv ***
// Purpose: Conversion sequencer, averaging, limit compare and status.
// Assumes: Register strobes arrive decoded from the serial slave.
// Notes: Reading registers keep their contents across both resets.
//
// Functional notes
// (R1) Start bit write begins monitoring.
// (R2) Finished measurement lands in readable reading register.
// (R3) Compare readings with limits, flag status.
// (R4) Power-up resets all but reading registers.
// (R5) Self-clearing soft reset spares reading registers.
// (R6) One bit picks continuous or cycle mode.
// (R7) Timing counted in conversion clock periods.
// (R8) Temperature conversion takes 96 periods.
// (R9) Voltage conversion takes 68 periods.
// (R10) Cycle length is inputs times averages.
// (R11) Three-bit field selects averages, both modes.
// (R12) All averages finish before reading update.
// (R13) Top averaging bit forces 32 averages.
// (R14) Zero field: remotes 128, others 8.
// (R15) Field 001: remotes 16, others one.
// (R16) Field resets 010, giving 16 everywhere.
// (R17) Fixed input order, remote one first.
// (R18) Continuous mode loops immediately while started.
// (R19) Cycle mode idles one second between sequences.
// (R20) Tick enable divided from system clock.
`include "mcs_defs.svh"

module mcs_sequencer
  import mcs_pkg::*;
#(
  // Cycle-mode rest and conversion clock divider; a simulation may shorten both.
  parameter int WAIT_TICKS = `MCS_WAIT_TICKS,
  parameter int TICK_DIV = `MCS_TICK_DIV
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Register access.
  input wire mcs_req_t req,
  output logic [7:0] reg_rdata,
  // Analog front end.
  input wire logic [7:0] adc_sample,
  input wire logic [1:0] diode_fault,
  output logic [2:0] adc_chan,
  output logic conv_active
);
  mcs_st_t st;
  mcs_st_t next_st;
  logic [7:0][7:0] reading;
  logic [7:0][7:0] next_reading;
  logic tick;
  logic is_temp;
  logic remote;
  logic [2:0] shift;
  logic [6:0] len;
  logic sample;
  logic last_avg;
  logic [7:0] avg_val;
  logic [14:0] acc;
  logic rdiode;
  logic srst;

  // ----------------------------------------
  // Conversion tick and per-input settings
  // ----------------------------------------
  // A tick pulses once per conversion clock period.
  assign tick = (st.div == 10'(TICK_DIV - 1)); // [R20] [R7]
  // Inputs run remote one, ambient, supplies, core, remote two.
  assign remote = (st.chan == 3'h0) || (st.chan == 3'h7); // [R17]
  assign is_temp = remote || (st.chan == 3'h1);
  assign rdiode = remote;
  // A setup write with the top bit set is a one-cycle soft reset.
  assign srst = req.wr && (req.addr == `MCS_OFF_SETUP) && req.wdata[`MCS_SRST_BIT]; // [R5]

  // Decode averaging from the top bit down into a shift count.
  always_comb begin
    if (st.avg[2]) begin
      shift = 3'h5; // [R13]
    end else if (st.avg[1]) begin
      shift = 3'h4; // [R16]
    end else if (st.avg[0]) begin
      shift = remote ? 3'h4 : 3'h0; // [R15]
    end else begin
      shift = remote ? 3'h7 : 3'h3; // [R14]
    end
  end

  // Conversion length depends on the kind of input.
  assign len = is_temp ? 7'(`MCS_TEMP_TICKS) : 7'(`MCS_VOLT_TICKS); // [R8] [R9]
  assign sample = (st.state == MCS_CONV) && tick && (st.ticks == len - 7'h1);
  // Averages per input times inputs sets the cycle length.
  assign last_avg = (st.navg == 7'((8'h1 << shift) - 8'h1)); // [R10] [R11]
  assign acc = st.sum + {7'h0, adc_sample};
  assign avg_val = 8'(acc >> shift);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Handles register writes, sequencing, averaging and status.
  always_comb begin
    logic [7:0] rv;
    logic v;
    logic [7:0] sset;
    logic [1:0] dset;
    rv = 8'h0;
    v = 1'b0;
    sset = 8'h0;
    dset = 2'h0;
    next_st = st;
    next_reading = reading;
    next_st.div = tick ? 10'h0 : st.div + 10'h1; // [R20]
    next_st.rdata = st.rdata;

    // Sequencer.
    case (st.state)
      MCS_IDLE: begin
        if (st.start) begin
          next_st.state = MCS_CONV; // [R1]
          next_st.chan = 3'h0;
          next_st.ticks = 7'h0;
          next_st.navg = 7'h0;
          next_st.sum = 15'h0;
        end
      end
      MCS_CONV: begin
        if (tick) begin
          next_st.ticks = st.ticks + 7'h1;
        end
        if (sample) begin
          next_st.ticks = 7'h0;
          next_st.sum = acc;
          next_st.navg = st.navg + 7'h1;
          if (last_avg) begin
            // Reading only changes once all averages are in.
            rv = avg_val; // [R12]
            if (rdiode && diode_fault[st.chan[2]]) begin
              rv = `MCS_FAULT_VAL;
              next_st.dstatus[st.chan[2]] = 1'b1; // [R3]
              dset[st.chan[2]] = 1'b1;
            end
            next_reading[st.chan] = rv; // [R2]
            v = (rv >= st.limit[st.chan]);
            next_st.viol[st.chan] = v;
            if (rdiode) begin
              next_st.dviol[st.chan[2]] = diode_fault[st.chan[2]];
            end
            if (v) begin
              next_st.status[st.chan] = 1'b1; // [R3]
              sset[st.chan] = 1'b1;
            end
            next_st.navg = 7'h0;
            next_st.sum = 15'h0;
            next_st.chan = st.chan + 3'h1; // [R17]
            if (st.chan == 3'h7) begin
              if (st.mode) begin
                next_st.state = MCS_WAIT; // [R6] [R19]
                next_st.wait_cnt = 16'h0;
              end else begin
                next_st.chan = 3'h0; // [R18]
              end
            end
          end
        end
      end
      MCS_WAIT: begin
        if (tick) begin
          next_st.wait_cnt = st.wait_cnt + 16'h1;
          if (st.wait_cnt == 16'(WAIT_TICKS - 1)) begin
            next_st.state = MCS_CONV; // [R19]
            next_st.chan = 3'h0;
            next_st.ticks = 7'h0;
          end
        end
      end
      default: begin
        next_st.state = MCS_IDLE;
      end
    endcase

    // Clearing start stops monitoring at once.
    if (!st.start) begin
      next_st.state = MCS_IDLE; // [R1]
    end

    // Register reads; a status read keeps only active causes.
    if (req.rd) begin
      if (req.addr == `MCS_OFF_START) begin
        next_st.rdata = {7'h0, st.start};
      end else if (req.addr == `MCS_OFF_STAT) begin
        next_st.rdata = st.status;
        // A set in the same cycle as the clearing read wins.
        next_st.status = st.viol | sset; // [R3]
      end else if (req.addr == `MCS_OFF_DFLT) begin
        next_st.rdata = {6'h0, st.dstatus};
        next_st.dstatus = st.dviol | dset; // [R3]
      end else if (req.addr == `MCS_OFF_SPEC) begin
        next_st.rdata = {st.avg, 2'h0, st.inten, st.mode, 1'b0};
      end else if (req.addr == `MCS_OFF_SETUP) begin
        next_st.rdata = 8'h0;
      end else if (req.addr[7:3] == 5'(`MCS_OFF_READ0 >> 3)) begin
        next_st.rdata = reading[req.addr[2:0]]; // [R2]
      end else if (req.addr >= `MCS_OFF_LIM0 && req.addr < `MCS_OFF_LIM0 + 8'h8) begin
        next_st.rdata = st.limit[3'(req.addr - `MCS_OFF_LIM0)];
      end else begin
        next_st.rdata = 8'h0;
      end
    end

    // Register writes.
    if (req.wr) begin
      if (req.addr == `MCS_OFF_START) begin
        next_st.start = req.wdata[`MCS_START_BIT]; // [R1]
      end else if (req.addr == `MCS_OFF_SPEC) begin
        next_st.avg = req.wdata[7:5]; // [R11]
        next_st.inten = req.wdata[`MCS_INTEN_BIT];
        next_st.mode = req.wdata[`MCS_MODE_BIT]; // [R6]
      end else if (req.addr >= `MCS_OFF_LIM0 && req.addr < `MCS_OFF_LIM0 + 8'h8) begin
        next_st.limit[3'(req.addr - `MCS_OFF_LIM0)] = req.wdata;
      end
    end

    // Registered copy of the converting state drives the activity pin.
    next_st.busy = (next_st.state == MCS_CONV);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Power-up and soft reset touch everything but the readings.
  always_ff @(posedge clock) begin
    st <= next_st;
    reading <= next_reading; // [R4]
    if (!rst_n || srst) begin
      st.state <= MCS_IDLE; // [R4] [R5]
      st.start <= 1'b0;
      st.mode <= 1'b0;
      st.inten <= 1'b0;
      st.avg <= `MCS_AVG_RST; // [R16]
      st.limit <= {8{`MCS_LIM_RST}};
      st.status <= 8'h0;
      st.dstatus <= 2'h0;
      st.viol <= 8'h0;
      st.dviol <= 2'h0;
      st.chan <= 3'h0;
      st.div <= 10'h0;
      st.ticks <= 7'h0;
      st.navg <= 7'h0;
      st.sum <= 15'h0;
      st.wait_cnt <= 16'h0;
      st.rdata <= 8'h0;
      st.busy <= 1'b0;
    end
  end

  // Outputs straight from flip-flops.
  assign reg_rdata = st.rdata;
  assign adc_chan = st.chan;
  assign conv_active = st.busy;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_idle_no_start: assert property (!st.start |=> st.state == MCS_IDLE) // [R1]
    else $error("Sequencer ran without start.");
  chk_soft_reset: assert property ( // [R5]
    req.wr && req.addr == `MCS_OFF_SETUP && req.wdata[7]
    |=> st.avg == 3'h2 && !st.start && st.status == 8'h0)
    else $error("Soft reset did not restore defaults.");
  chk_temp_len: assert property (sample && is_temp |-> st.ticks == 7'd95) // [R8]
    else $error("Temperature conversion length wrong.");
  chk_volt_len: assert property (sample && !is_temp |-> st.ticks == 7'd67) // [R9]
    else $error("Voltage conversion length wrong.");
  chk_avg_top: assert property (st.avg[2] |-> shift == 3'h5) // [R13]
    else $error("Top bit did not force 32 averages.");
  chk_avg_zero: assert property (st.avg == 3'h0 |-> shift == (remote ? 3'h7 : 3'h3)) // [R14]
    else $error("Zero field averages wrong.");
  chk_avg_one: assert property (st.avg == 3'h1 |-> shift == (remote ? 3'h4 : 3'h0)) // [R15]
    else $error("Field 001 averages wrong.");
  chk_cont_loop: assert property ( // [R18]
    sample && last_avg && st.chan == 3'h7 && !st.mode && st.start && !srst
    |=> st.state == MCS_CONV && st.chan == 3'h0)
    else $error("Continuous mode did not loop.");
  chk_cycle_wait: assert property ( // [R19]
    sample && last_avg && st.chan == 3'h7 && st.mode && st.start && !srst
    |=> st.state == MCS_WAIT ##1 st.state != MCS_CONV)
    else $error("Cycle mode did not idle.");
  chk_limit_flag: assert property ( // [R3]
    sample && last_avg && st.start && !srst && !(rdiode && diode_fault[st.chan[2]])
    && avg_val >= st.limit[st.chan] |=> st.status[$past(st.chan)])
    else $error("Out-of-limit reading not flagged.");
  chk_chan_step: assert property ( // [R17]
    sample && last_avg && st.start && !srst |=> st.chan == $past(st.chan) + 3'h1)
    else $error("Input order did not advance by one.");
  chk_status_sticky: assert property ( // [R3]
    !(req.rd && req.addr == `MCS_OFF_STAT) && !srst
    |=> ($past(st.status) & ~st.status) == 8'h0)
    else $error("Status bit cleared without a read.");

  cov_cont_wrap: cover property (st.chan == 3'h7 && sample && last_avg && !st.mode);
  cov_cycle_wait: cover property (st.state == MCS_WAIT);
  cov_status_set: cover property ($rose(st.status[0]));
  cov_diode_fault: cover property (st.dstatus != 2'h0);
  cov_soft_reset: cover property (srst);
endmodule : mcs_sequencer
